// ==== bench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic instrValid = 1'b0;
  logic instrReady;
  core_ops_pkg::instr_t instr = '0;
  logic [7:0] fileRdData;
  logic fileWrEn, wdtClear, prescalerClear, oscStop, hreadyout, hresp;
  logic [6:0] fileWrAddr;
  logic [7:0] fileWrData, wdtCount;
  logic callPush = 1'b0;
  logic [core_ops_pkg::PC_W-1:0] callAddr = '0;
  logic [core_ops_pkg::PC_W-1:0] pc;
  logic wake = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [2:0] hsize = 3'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [31:0] rdv;
  logic [7:0] fileMem [128];
  int error_cnt = 0;
  int samples_checked = 0;

  // 4 ns period
  always #2 clk = ~clk;

  // the register file beside the block: read combinationally, written on the pulse
  assign fileRdData = fileMem[instr.fileAddr];
  always @(posedge clk) begin
    if (fileWrEn === 1'b1) fileMem[fileWrAddr] <= fileWrData;
  end

  // single slave, so its ready is the bus ready
  return_rotate_sleep_alu_ops DUT (
    .clk(clk), .rst_b(rst_b), .instrValid(instrValid), .instrReady(instrReady),
    .instr(instr), .fileRdData(fileRdData), .fileWrEn(fileWrEn),
    .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .callPush(callPush),
    .callAddr(callAddr), .pc(pc), .wdtCount(wdtCount), .wdtClear(wdtClear),
    .prescalerClear(prescalerClear), .oscStop(oscStop), .wake(wake), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
  );

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // bounded wait for a handshake; a hang is counted and ends the run
  task automatic await(input bit useInstr);
    int n;
    n = 0;
    @(posedge clk);
    while ((useInstr ? instrReady : hreadyout) !== 1'b1) begin
      n++;
      if (n > 50) begin
        check(32'h0, 32'h1);
        report_and_stop();
      end
      @(posedge clk);
    end
  endtask : await

  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    await(1'b0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    await(1'b0);
    rd = hrdata;
    check({30'h0, hreadyout, hresp}, 32'h2);
  endtask : bus

  task automatic issue(input logic [2:0] op, input logic [7:0] lit, input logic [6:0] fa,
                       input logic d);
    @(posedge clk);
    instrValid <= 1'b1;
    instr <= '{op: op, literal: lit, fileAddr: fa, dest: d};
    await(1'b1);
    instrValid <= 1'b0;
    #1;
  endtask : issue

  task automatic push(input logic [12:0] a);
    @(posedge clk);
    callPush <= 1'b1;
    callAddr <= a;
    @(posedge clk);
    callPush <= 1'b0;
  endtask : push

  // literal minus accumulator over borrow, no-borrow and zero cases
  task automatic sub_cases();
    logic [7:0] wTab [3] = '{8'h05, 8'h03, 8'h01};
    logic [7:0] kTab [3] = '{8'h03, 8'h03, 8'h10};
    logic [7:0] res;
    logic [2:0] fl;
    for (int i = 0; i < 3; i++) begin
      res = kTab[i] - wTab[i];
      fl = {res == 8'h00, kTab[i][3:0] >= wTab[i][3:0], kTab[i] >= wTab[i]};
      bus(1'b1, core_ops_pkg::ADDR_ACCUM, {24'h0, wTab[i]}, rdv);
      bus(1'b1, core_ops_pkg::ADDR_STATUS, 32'h0, rdv);
      issue(core_ops_pkg::OP_SUB_LIT, kTab[i], 7'h00, 1'b0);
      bus(1'b0, core_ops_pkg::ADDR_ACCUM, 32'h0, rdv);
      check(rdv, {24'h0, res});
      bus(1'b0, core_ops_pkg::ADDR_STATUS, 32'h0, rdv);
      check(rdv, {27'h0, 2'b11, fl});
    end
  endtask : sub_cases

  // xor to zero and to non-zero; carry and digit carry must survive; unused code 6 does nothing
  task automatic xor_cases();
    bus(1'b1, core_ops_pkg::ADDR_ACCUM, 32'h5A, rdv);
    bus(1'b1, core_ops_pkg::ADDR_STATUS, 32'h3, rdv);
    issue(core_ops_pkg::OP_XOR_LIT, 8'h5A, 7'h00, 1'b0);
    bus(1'b0, core_ops_pkg::ADDR_ACCUM, 32'h0, rdv);
    check(rdv, 32'h0);
    bus(1'b0, core_ops_pkg::ADDR_STATUS, 32'h0, rdv);
    check(rdv, 32'h1F);
    issue(core_ops_pkg::OP_XOR_LIT, 8'hFF, 7'h00, 1'b0);
    bus(1'b0, core_ops_pkg::ADDR_ACCUM, 32'h0, rdv);
    check(rdv, 32'hFF);
    bus(1'b0, core_ops_pkg::ADDR_STATUS, 32'h0, rdv);
    check(rdv, 32'h1B);
    issue(3'h6, 8'h33, 7'h00, 1'b1);
    check({31'h0, fileWrEn}, 32'h0);
    bus(1'b0, core_ops_pkg::ADDR_ACCUM, 32'h0, rdv);
    check(rdv, 32'hFF);
    bus(1'b0, core_ops_pkg::ADDR_STATUS, 32'h0, rdv);
    check(rdv, 32'h1B);
  endtask : xor_cases

  // rotate of the top register address into the accumulator, then back into the file
  task automatic rotate_cases();
    fileMem[127] = 8'h81;
    bus(1'b1, core_ops_pkg::ADDR_STATUS, 32'h6, rdv);
    issue(core_ops_pkg::OP_ROTATE, 8'h00, 7'h7F, core_ops_pkg::DEST_ACC);
    check({31'h0, fileWrEn}, 32'h0);
    bus(1'b0, core_ops_pkg::ADDR_ACCUM, 32'h0, rdv);
    check(rdv, 32'h40);
    bus(1'b0, core_ops_pkg::ADDR_STATUS, 32'h0, rdv);
    check(rdv, 32'h1F);
    issue(core_ops_pkg::OP_ROTATE, 8'h00, 7'h7F, core_ops_pkg::DEST_FILE);
    check({31'h0, fileWrEn}, 32'h1);
    check({25'h0, fileWrAddr}, 32'h7F);
    check({24'h0, fileWrData}, 32'hC0);
    bus(1'b0, core_ops_pkg::ADDR_ACCUM, 32'h0, rdv);
    check(rdv, 32'h40);
    check({24'h0, fileMem[127]}, 32'hC0);
  endtask : rotate_cases

  // returns pop the stack in reverse order and refuse the following cycle
  task automatic return_cases();
    push(13'h1ABC);
    issue(core_ops_pkg::OP_RET_LIT, 8'hA5, 7'h00, 1'b0);
    check({19'h0, pc}, 32'h1ABC);
    check({31'h0, instrReady}, 32'h0);
    bus(1'b0, core_ops_pkg::ADDR_ACCUM, 32'h0, rdv);
    check(rdv, 32'hA5);
    bus(1'b0, core_ops_pkg::ADDR_STATUS, 32'h0, rdv);
    check(rdv, 32'h1F);
    push(13'h0123);
    push(13'h0456);
    bus(1'b0, core_ops_pkg::ADDR_STACK, 32'h0, rdv);
    check(rdv, 32'h2);
    issue(core_ops_pkg::OP_RETURN, 8'h00, 7'h00, 1'b0);
    check({19'h0, pc}, 32'h0456);
    check({31'h0, instrReady}, 32'h0);
    issue(core_ops_pkg::OP_RETURN, 8'h00, 7'h00, 1'b0);
    check({19'h0, pc}, 32'h0123);
    bus(1'b0, core_ops_pkg::ADDR_STATUS, 32'h0, rdv);
    check(rdv, 32'h1F);
  endtask : return_cases

  // sleep: pulses, cleared watchdog, status bits, halt until wake
  task automatic sleep_case();
    issue(core_ops_pkg::OP_SLEEP, 8'h00, 7'h00, 1'b0);
    check({30'h0, wdtClear, prescalerClear}, 32'h3);
    check({24'h0, wdtCount}, 32'h0);
    check({30'h0, oscStop, instrReady}, 32'h2);
    @(posedge clk);
    #1;
    check({30'h0, wdtClear, prescalerClear}, 32'h0);
    repeat (3) @(posedge clk);
    #1;
    check({24'h0, wdtCount}, 32'h0);
    bus(1'b0, core_ops_pkg::ADDR_STATUS, 32'h0, rdv);
    check(rdv, 32'h17);
    bus(1'b0, core_ops_pkg::ADDR_CONTROL, 32'h0, rdv);
    check(rdv & 32'h1, 32'h1);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    #1;
    check({30'h0, oscStop, instrReady}, 32'h1);
    bus(1'b0, core_ops_pkg::ADDR_CONTROL, 32'h0, rdv);
    check(rdv, 32'h0);
    // power-down and expiry are read-only to the bus
    bus(1'b1, core_ops_pkg::ADDR_STATUS, 32'h18, rdv);
    bus(1'b0, core_ops_pkg::ADDR_STATUS, 32'h0, rdv);
    check(rdv, 32'h10);
    // second sleep, this time woken by a control write
    issue(core_ops_pkg::OP_SLEEP, 8'h00, 7'h00, 1'b0);
    check({30'h0, oscStop, instrReady}, 32'h2);
    bus(1'b1, core_ops_pkg::ADDR_CONTROL, 32'h1, rdv);
    #1;
    check({30'h0, oscStop, instrReady}, 32'h1);
  endtask : sleep_case

  // main sequence: reset, reset values, unmapped read, then each instruction
  initial begin
    for (int i = 0; i < 128; i++) fileMem[i] = 8'h00;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, core_ops_pkg::ADDR_STATUS, 32'h0, rdv);
    check(rdv, 32'h18);
    bus(1'b0, core_ops_pkg::ADDR_PC, 32'h0, rdv);
    check(rdv, 32'h0);
    bus(1'b0, 8'h20, 32'h0, rdv);
    check(rdv, 32'h0);
    sub_cases();
    xor_cases();
    rotate_cases();
    return_cases();
    sleep_case();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire

// ==== verilog/core_ops_pkg.sv ====
package core_ops_pkg;

  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;

  // operation codes on the issue port
  localparam logic [2:0] OP_RET_LIT = 3'h0;
  localparam logic [2:0] OP_RETURN = 3'h1;
  localparam logic [2:0] OP_ROTATE = 3'h2;
  localparam logic [2:0] OP_SLEEP = 3'h3;
  localparam logic [2:0] OP_SUB_LIT = 3'h4;
  localparam logic [2:0] OP_XOR_LIT = 3'h5;

  localparam logic DEST_ACC = 1'h0;
  localparam logic DEST_FILE = 1'h1;

  // byte addresses of the register words
  localparam logic [7:0] ADDR_ACCUM = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_STACK = 8'h10;

  // status and control word bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_DCARRY = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PDOWN = 3;
  localparam int ST_EXPIRY = 4;
  localparam int CTL_WAKE = 0;

  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [4:0] STATUS_RST = 5'h18;
  localparam logic [7:0] WDT_CLEARED = 8'h00;

  typedef struct packed {
    logic [2:0] op;
    logic [7:0] literal;
    logic [6:0] fileAddr;
    logic dest;
  } instr_t;

  typedef struct packed {
    logic expiry;
    logic powerDown;
    logic zero;
    logic digitCarry;
    logic carry;
  } status_t;

  typedef enum logic [2:0] {
    RUN = 3'b001,
    SECOND = 3'b010,
    ASLEEP = 3'b100
  } state_t;

endpackage : core_ops_pkg

// ==== verilog/return_rotate_sleep_alu_ops.sv ====
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module return_rotate_sleep_alu_ops (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic instrValid,
  output logic instrReady,
  input wire core_ops_pkg::instr_t instr,
  input wire logic [7:0] fileRdData,
  output logic fileWrEn,
  output logic [6:0] fileWrAddr,
  output logic [7:0] fileWrData,
  input wire logic callPush,
  input wire logic [core_ops_pkg::PC_W-1:0] callAddr,
  output logic [core_ops_pkg::PC_W-1:0] pc,
  output logic [7:0] wdtCount,
  output logic wdtClear,
  output logic prescalerClear,
  output logic oscStop,
  input wire logic wake,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  core_ops_pkg::state_t state;
  logic [7:0] accum;
  core_ops_pkg::status_t status;
  logic [core_ops_pkg::PC_W-1:0] stack [core_ops_pkg::STACK_DEPTH];
  logic [core_ops_pkg::SP_W-1:0] stackPtr;
  logic [core_ops_pkg::SP_W:0] stackFill;
  logic [core_ops_pkg::PC_W-1:0] stackTop;
  logic accept;
  logic isPop;
  logic [8:0] subWide;
  logic [4:0] subNibble;
  logic [7:0] subResult;
  logic [7:0] xorResult;
  logic [7:0] rotResult;
  logic busWrPend;
  logic [7:0] busWrAddr;
  logic busAccumWr;
  logic busStatusWr;
  logic busWake;

  // register read mux; unmapped words read as zero
  function automatic logic [31:0] regRead(input logic [7:0] a);
    case (a)
      core_ops_pkg::ADDR_ACCUM: regRead = {24'h000000, accum};
      core_ops_pkg::ADDR_STATUS: regRead = {27'h0000000, status};
      core_ops_pkg::ADDR_PC: regRead = {19'h00000, pc};
      core_ops_pkg::ADDR_CONTROL: regRead = {31'h00000000, state == core_ops_pkg::ASLEEP};
      core_ops_pkg::ADDR_STACK: regRead = {28'h0000000, stackFill};
      default: regRead = 32'h00000000;
    endcase
  endfunction : regRead

  // zero test shared by the subtract and xor updates of Z
  function automatic logic isZero(input logic [7:0] v);
    isZero = (v == 8'h00);
  endfunction : isZero

  // issue handshake: only a running core takes an instruction
  assign instrReady = (state == core_ops_pkg::RUN);
  assign accept = instrValid && instrReady;
  assign isPop = accept && (instr.op == core_ops_pkg::OP_RET_LIT ||
                            instr.op == core_ops_pkg::OP_RETURN);
  assign oscStop = (state == core_ops_pkg::ASLEEP);
  assign stackTop = stack[stackPtr - 3'h1];

  // datapath results; carry and digit carry are the inverted borrows
  assign subWide = {1'h0, instr.literal} - {1'h0, accum};
  assign subNibble = {1'h0, instr.literal[3:0]} - {1'h0, accum[3:0]};
  assign subResult = subWide[7:0];
  assign xorResult = accum ^ instr.literal;
  assign rotResult = {status.carry, fileRdData[7:1]};

  // bus side strobes decoded in the data phase
  assign busAccumWr = busWrPend && (busWrAddr == core_ops_pkg::ADDR_ACCUM);
  assign busStatusWr = busWrPend && (busWrAddr == core_ops_pkg::ADDR_STATUS);
  assign busWake = busWrPend && (busWrAddr == core_ops_pkg::ADDR_CONTROL) &&
                   hwdata[core_ops_pkg::CTL_WAKE];
  assign hreadyout = 1'h1;
  assign hresp = 1'h0;

  // sequencer: returns take a flushed second cycle, sleep holds until woken
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= core_ops_pkg::RUN;
    end else begin
      case (state)
        core_ops_pkg::RUN: begin
          if (isPop) begin
            state <= core_ops_pkg::SECOND;
          end else if (accept && instr.op == core_ops_pkg::OP_SLEEP) begin
            state <= core_ops_pkg::ASLEEP;
          end
        end
        core_ops_pkg::SECOND: state <= core_ops_pkg::RUN;
        core_ops_pkg::ASLEEP: begin
          if (wake || busWake) begin
            state <= core_ops_pkg::RUN;
          end
        end
        default: state <= core_ops_pkg::RUN;
      endcase
    end
  end

  // accumulator: an executing instruction wins over a bus write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accum <= core_ops_pkg::ACCUM_RST;
    end else if (accept && instr.op == core_ops_pkg::OP_RET_LIT) begin
      accum <= instr.literal;
    end else if (accept && instr.op == core_ops_pkg::OP_SUB_LIT) begin
      accum <= subResult;
    end else if (accept && instr.op == core_ops_pkg::OP_XOR_LIT) begin
      accum <= xorResult;
    end else if (accept && instr.op == core_ops_pkg::OP_ROTATE &&
                 instr.dest == core_ops_pkg::DEST_ACC) begin
      accum <= rotResult;
    end else if (busAccumWr) begin
      accum <= hwdata[7:0];
    end
  end

  // status: bus writes the arithmetic flags, then instruction effects override
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= core_ops_pkg::STATUS_RST;
    end else begin
      if (busStatusWr) begin
        status.carry <= hwdata[core_ops_pkg::ST_CARRY];
        status.digitCarry <= hwdata[core_ops_pkg::ST_DCARRY];
        status.zero <= hwdata[core_ops_pkg::ST_ZERO];
      end
      if (accept) begin
        case (instr.op)
          core_ops_pkg::OP_ROTATE: status.carry <= fileRdData[0];
          core_ops_pkg::OP_SUB_LIT: begin
            status.carry <= ~subWide[8];
            status.digitCarry <= ~subNibble[4];
            status.zero <= isZero(subResult);
          end
          core_ops_pkg::OP_XOR_LIT: status.zero <= isZero(xorResult);
          core_ops_pkg::OP_SLEEP: begin
            status.powerDown <= 1'h0;
            status.expiry <= 1'h1;
          end
          default: status.zero <= status.zero;
        endcase
      end
    end
  end

  // file register write-back of the rotate, one cycle after issue
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fileWrEn <= 1'h0;
      fileWrAddr <= 7'h00;
      fileWrData <= 8'h00;
    end else begin
      fileWrEn <= accept && instr.op == core_ops_pkg::OP_ROTATE &&
                  instr.dest == core_ops_pkg::DEST_FILE;
      if (accept && instr.op == core_ops_pkg::OP_ROTATE) begin
        fileWrAddr <= instr.fileAddr;
        fileWrData <= rotResult;
      end
    end
  end

  // return stack wraps like the hardware one; a pop takes priority over a push
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stackPtr <= '0;
      stackFill <= '0;
    end else if (isPop) begin
      stackPtr <= stackPtr - 3'h1;
      if (stackFill != 4'h0) begin
        stackFill <= stackFill - 4'h1;
      end
    end else if (callPush) begin
      stackPtr <= stackPtr + 3'h1;
      if (stackFill != 4'h8) begin
        stackFill <= stackFill + 4'h1;
      end
    end
  end

  // stack storage; no reset so it maps to plain memory
  always_ff @(posedge clk) begin
    if (callPush && !isPop) begin
      stack[stackPtr] <= callAddr;
    end
  end

  // program counter reload from the popped entry
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc <= core_ops_pkg::PC_RST;
    end else if (isPop) begin
      pc <= stackTop;
    end
  end

  // watchdog clear strobes and counter image; the image counts up each cycle unless asleep
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdtClear <= 1'h0;
      prescalerClear <= 1'h0;
      wdtCount <= core_ops_pkg::WDT_CLEARED;
    end else begin
      wdtClear <= accept && instr.op == core_ops_pkg::OP_SLEEP;
      prescalerClear <= accept && instr.op == core_ops_pkg::OP_SLEEP;
      if (accept && instr.op == core_ops_pkg::OP_SLEEP) begin
        wdtCount <= core_ops_pkg::WDT_CLEARED;
      end else if (!oscStop) begin
        wdtCount <= wdtCount + 8'h01;
      end
    end
  end

  // ahb-lite address phase capture; zero wait states, always okay
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busWrPend <= 1'h0;
      busWrAddr <= 8'h00;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      busWrPend <= hsel && htrans[1] && hwrite;
      busWrAddr <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        hrdata <= regRead(haddr[7:0]);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  ret_lit_acc_a: assert property (accept && instr.op == core_ops_pkg::OP_RET_LIT |=>
    accum == $past(instr.literal) && status.carry == $past(status.carry))
    else $error("return with literal did not load the accumulator");

  ret_lit_pc_a: assert property (accept && instr.op == core_ops_pkg::OP_RET_LIT |=>
    pc == $past(stackTop) && !instrReady ##1 instrReady)
    else $error("return with literal pc or cycle count wrong");

  return_pc_a: assert property (accept && instr.op == core_ops_pkg::OP_RETURN |=>
    pc == $past(stackTop) && accum == $past(accum) && !instrReady ##1 instrReady)
    else $error("return did not reload pc in two cycles");

  rotate_carry_a: assert property (accept && instr.op == core_ops_pkg::OP_ROTATE |=>
    status.carry == $past(fileRdData[0]) && fileWrData == {$past(status.carry),
    $past(fileRdData[7:1])})
    else $error("rotate carry or result wrong");

  rotate_dest_a: assert property (accept && instr.op == core_ops_pkg::OP_ROTATE |=>
    fileWrEn == $past(instr.dest) && ($past(instr.dest) || accum == fileWrData))
    else $error("rotate written to the wrong destination");

  sleep_flags_a: assert property (accept && instr.op == core_ops_pkg::OP_SLEEP |=>
    !status.powerDown && status.expiry)
    else $error("sleep flags not updated");

  sleep_wdt_a: assert property (accept && instr.op == core_ops_pkg::OP_SLEEP |=>
    wdtClear && prescalerClear && wdtCount == 8'h00 ##1 !wdtClear)
    else $error("sleep did not clear watchdog");

  sleep_halt_a: assert property (accept && instr.op == core_ops_pkg::OP_SLEEP ##1 !wake
    |-> oscStop && !instrReady && $stable(pc))
    else $error("sleep did not halt execution");

  sub_flags_a: assert property (accept && instr.op == core_ops_pkg::OP_SUB_LIT |=>
    accum == 8'($past(instr.literal) - $past(accum)) &&
    status.carry == ($past(instr.literal) >= $past(accum)) &&
    status.digitCarry == ($past(instr.literal[3:0]) >= $past(accum[3:0])))
    else $error("subtract result or borrow flags wrong");

  xor_zero_a: assert property (accept && instr.op == core_ops_pkg::OP_XOR_LIT |=>
    accum == ($past(accum) ^ $past(instr.literal)) && status.zero == (accum == 8'h00) &&
    status.carry == $past(status.carry))
    else $error("xor result or zero flag wrong");

  // pointer step, wake-up and frozen watchdog image around the pop and sleep paths
  stack_pop_a: assert property (isPop |=> stackPtr == $past(stackPtr) - 3'h1)
    else $error("return did not pop the stack");

  wake_resume_a: assert property (oscStop && (wake || busWake) |=> instrReady)
    else $error("wake did not resume execution");

  wdt_frozen_a: assert property (oscStop |=> wdtCount == $past(wdtCount))
    else $error("watchdog image moved while asleep");

endmodule : return_rotate_sleep_alu_ops
`default_nettype wire
